// *** verilog/dbcm_pkg.sv ***
// Purpose: Shared constants and types for the dual buck clock and mode control block
// Assumes: System clock of 250 MHz; all counts derive from it
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
package dbcm_pkg;

	// System clock and switching frequencies
	localparam int unsigned SYS_CLK_HZ = 250_000_000;
	localparam int unsigned FSW_LOW_HZ = 200_000;
	localparam int unsigned FSW_MID_HZ = 300_000;
	localparam int unsigned FSW_HIGH_HZ = 400_000;
	localparam int unsigned HF_MULT = 4;

	// Half period of the high-frequency clock in system cycles, rounded down
	function automatic int unsigned half_cycles(input int unsigned fsw_hz);
		return SYS_CLK_HZ / (2 * HF_MULT * fsw_hz);
	endfunction

	localparam int HALF_W = 8;
	localparam logic [HALF_W-1:0] HALF_LOW = HALF_W'(half_cycles(FSW_LOW_HZ));
	localparam logic [HALF_W-1:0] HALF_MID = HALF_W'(half_cycles(FSW_MID_HZ));
	localparam logic [HALF_W-1:0] HALF_HIGH = HALF_W'(half_cycles(FSW_HIGH_HZ));

	// Frequency select pin codes: bit 0 tied high, bit 1 left open
	localparam logic [1:0] FSEL_GND = 2'h0;
	localparam logic [1:0] FSEL_VCC = 2'h1;
	localparam logic [1:0] FSEL_OPEN = 2'h2;

	// Half high-frequency ticks in one switching period, and phase of channel 1
	localparam int PH_W = 3;
	localparam logic [PH_W-1:0] PH_LAST = 3'h7;
	localparam logic [PH_W-1:0] PH_CH0 = 3'h0;
	localparam logic [PH_W-1:0] PH_CH1 = 3'h4;

	// On-time in half high-frequency ticks
	localparam int DUTY_W = 3;
	localparam int TICK_W = 4;
	localparam logic [DUTY_W-1:0] DUTY_RST = 3'h3;

	// Skip on-time is 1.5 times the continuous on-time, rounded up
	function automatic logic [TICK_W-1:0] skip_ticks(input logic [DUTY_W-1:0] duty);
		logic [TICK_W+1:0] x3;
		x3 = {3'h0, duty} + {2'h0, duty, 1'b0} + 6'h01;
		return x3[TICK_W:1];
	endfunction

	// Consecutive periods with negative current before entering skip
	localparam int NEG_W = 2;
	localparam logic [NEG_W-1:0] NEG_PERIODS = 2'h3;

	// Register map
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_DUTY0 = 4'h0;
	localparam logic [ADDR_W-1:0] REG_DUTY1 = 4'h4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'hc;
	localparam logic [1:0] CTRL_RST = 2'h3;
	localparam int ST_SKIP0 = 0;
	localparam int ST_SKIP1 = 1;
	localparam int ST_FSEL = 2;
	localparam int ST_PSKIP = 4;
	localparam int ST_SS0 = 5;
	localparam int ST_SS1 = 6;

	// Pin inputs as they arrive, before synchronisation
	typedef struct packed {
		logic       forced_pwm_select_n;
		logic [1:0] frequency_select_pin;
		logic [1:0] soft_start;
		logic [1:0] fb_below_droop;
		logic [1:0] il_negative;
	} dbcm_pins_t;

	// Gate drive pair of one channel
	typedef struct packed {
		logic hs;
		logic ls;
	} dbcm_gate_t;

	typedef enum logic [1:0] {MODE_CCM, MODE_SKIP, MODE_RESYNC} dbcm_mode_t;

endpackage

// *** verilog/dbcm_clkgen.sv ***
// Purpose: High-frequency clock and two interleaved switching clocks
// Assumes: half_cnt is at least one and changes only with the select pin
// Notes:   All outputs are registered
`timescale 1ns/1ps
module dbcm_clkgen
	import dbcm_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic [dbcm_pkg::HALF_W-1:0] half_cnt,
	output logic                            hf_clk,
	output logic                            hf_edge,
	output logic [1:0]                      period_start,
	output logic [1:0]                      sw_clk
);
	logic [HALF_W-1:0] cnt_ff;
	logic [PH_W-1:0]   phase_ff;
	logic              wrap;
	logic [PH_W-1:0]   nxt_phase;

	// Half-period wrap; >= keeps a shortened count from running away
	assign wrap = (cnt_ff >= half_cnt - HALF_W'(1));
	assign nxt_phase = phase_ff + PH_W'(1);

	// Divider, 50% high-frequency clock, phase count of eight half ticks
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= '0;
			phase_ff <= PH_LAST;
			hf_clk <= 1'b0;
			hf_edge <= 1'b0;
			period_start <= 2'h0;
			sw_clk <= 2'h0;
		end
		else if (ce)
		begin
			cnt_ff <= wrap ? '0 : cnt_ff + HALF_W'(1);
			hf_edge <= wrap;
			period_start <= {wrap && nxt_phase == PH_CH1, wrap && nxt_phase == PH_CH0};
			if (wrap)
			begin
				hf_clk <= ~hf_clk;
				phase_ff <= nxt_phase;
				sw_clk <= {nxt_phase >= PH_CH1, nxt_phase < PH_CH1};
			end
		end
	end
endmodule

// *** verilog/dbcm_channel.sv ***
// Purpose: Mode state and gate timing for one buck channel
// Assumes: Inputs are already synchronised to clk_sys
// Notes:   On-time counts in half high-frequency ticks
`timescale 1ns/1ps
module dbcm_channel
	import dbcm_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic                       enable,
	input  wire logic                       hf_edge,
	input  wire logic                       period_start,
	input  wire logic [dbcm_pkg::DUTY_W-1:0] ccm_duty,
	input  wire logic                       force_ccm,
	input  wire logic                       fb_below,
	input  wire logic                       il_neg,
	output dbcm_pkg::dbcm_gate_t            gate,
	output logic                            in_skip
);
	dbcm_mode_t        mode_ff, nxt_mode;
	logic [TICK_W-1:0] tick_ff, nxt_tick;
	logic [NEG_W-1:0]  neg_cnt_ff, nxt_neg_cnt;
	logic              hs_ff, nxt_hs;
	logic              off_ok_ff, nxt_off_ok;
	logic              saw_neg_ff, nxt_saw_neg;
	logic              on_end, ccm_start, skip_start;

	assign on_end = hs_ff && hf_edge && tick_ff <= TICK_W'(1);
	assign ccm_start = period_start && ccm_duty != '0 && mode_ff != MODE_SKIP;
	// Skip pulse only after the minimum off-time and with the current seen negative
	assign skip_start = mode_ff == MODE_SKIP && !hs_ff && hf_edge && off_ok_ff
		&& fb_below && saw_neg_ff && !force_ccm;

	// Next-state decode of mode, on-time and negative-current tracking
	always_comb
	begin
		nxt_mode = mode_ff;
		nxt_tick = tick_ff;
		nxt_hs = hs_ff;
		nxt_off_ok = off_ok_ff;
		nxt_neg_cnt = neg_cnt_ff;
		nxt_saw_neg = saw_neg_ff | il_neg;
		if (hs_ff && hf_edge)
			nxt_tick = tick_ff - TICK_W'(1);
		if (on_end)
		begin
			nxt_hs = 1'b0;
			nxt_off_ok = 1'b0;
		end
		else if (!hs_ff && hf_edge)
			nxt_off_ok = 1'b1;
		unique case (mode_ff)
			MODE_CCM:
			begin
				if (period_start)
				begin
					nxt_neg_cnt = saw_neg_ff ? neg_cnt_ff + NEG_W'(1) : '0;
					nxt_saw_neg = il_neg;
					if (!force_ccm && saw_neg_ff && neg_cnt_ff == NEG_PERIODS - NEG_W'(1))
					begin
						nxt_mode = MODE_SKIP;
						nxt_saw_neg = 1'b1;
					end
				end
			end
			MODE_SKIP:
			begin
				if (force_ccm)
					nxt_mode = MODE_RESYNC;
				else if (!hs_ff && hf_edge && off_ok_ff && fb_below && !saw_neg_ff)
					nxt_mode = MODE_RESYNC;
				if (skip_start)
				begin
					nxt_hs = 1'b1;
					nxt_tick = skip_ticks(ccm_duty);
					nxt_saw_neg = il_neg; // Set wins over the clear at pulse start
				end
			end
			MODE_RESYNC:
			begin
				if (period_start)
				begin
					nxt_mode = MODE_CCM;
					nxt_neg_cnt = '0;
					nxt_saw_neg = il_neg;
				end
			end
		endcase
		if (ccm_start && (mode_ff == MODE_CCM || period_start))
		begin
			nxt_hs = 1'b1;
			nxt_tick = {1'b0, ccm_duty};
		end
		if (!enable)
		begin
			nxt_mode = MODE_CCM;
			nxt_hs = 1'b0;
			nxt_neg_cnt = '0;
			nxt_saw_neg = 1'b0;
		end
	end

	// State and gate registers; while enabled, low side follows the high side's complement except in skip with negative current seen
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_ff <= MODE_CCM;
			tick_ff <= '0;
			hs_ff <= 1'b0;
			off_ok_ff <= 1'b1;
			neg_cnt_ff <= '0;
			saw_neg_ff <= 1'b0;
			gate <= '0;
		end
		else if (ce)
		begin
			mode_ff <= nxt_mode;
			tick_ff <= nxt_tick;
			hs_ff <= nxt_hs;
			off_ok_ff <= nxt_off_ok;
			neg_cnt_ff <= nxt_neg_cnt;
			saw_neg_ff <= nxt_saw_neg;
			gate.hs <= nxt_hs;
			// In skip the low side drops once current turns negative
			gate.ls <= enable && !nxt_hs
				&& !(nxt_mode == MODE_SKIP && nxt_saw_neg);
		end
	end

	assign in_skip = mode_ff == MODE_SKIP;
endmodule

// *** verilog/dbcm_top.sv ***
// Purpose: Clock and mode control of a two-channel synchronous buck controller
// Assumes: Pin inputs are asynchronous; Avalon-MM master on clk_sys
// Notes:   Gate outputs are registered; the analog loop sits outside
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module dbcm_top
	import dbcm_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic                       enable,
	input  wire dbcm_pkg::dbcm_pins_t       pin_in,
	input  wire logic [dbcm_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic [31:0]                     avs_readdata,
	output logic                            avs_waitrequest,
	output dbcm_pkg::dbcm_gate_t            gate_ch0,
	output dbcm_pkg::dbcm_gate_t            gate_ch1,
	output logic                            hf_clk,
	output logic [1:0]                      sw_clk
);
	dbcm_pins_t        sync1_ff;
	dbcm_pins_t        pins_ff;
	logic              enable_s1_ff;
	logic              enable_ff;
	logic [HALF_W-1:0] half_cnt_ff;
	logic [HALF_W-1:0] nxt_half_cnt;
	logic [DUTY_W-1:0] duty0_ff;
	logic [DUTY_W-1:0] duty1_ff;
	logic [1:0]        ctrl_ff;
	logic              ack_ff;
	logic [31:0]       rdata_ff;
	logic [31:0]       nxt_rdata;
	logic [31:0]       status_word;
	logic              req;
	logic              take;
	logic              hit_duty0;
	logic              hit_duty1;
	logic              hit_ctrl;
	logic              hit_status;
	logic              pulse_skip_operation;
	logic              forced_pwm_mode;
	logic [1:0]        force_ccm;
	logic              hf_edge;
	logic [1:0]        period_start;
	logic [1:0]        in_skip;

	// Two-stage synchronisers on every pin input
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_ff <= '0;
			pins_ff <= '0;
			enable_s1_ff <= 1'b0;
			enable_ff <= 1'b0;
		end
		else if (ce)
		begin
			sync1_ff <= pin_in;
			pins_ff <= sync1_ff;
			enable_s1_ff <= enable;
			enable_ff <= enable_s1_ff;
		end
	end

	// Frequency select decode; the unused code falls back to the middle rate
	assign nxt_half_cnt =
		(pins_ff.frequency_select_pin == FSEL_GND)  ? HALF_LOW :
		(pins_ff.frequency_select_pin == FSEL_VCC)  ? HALF_MID :
		(pins_ff.frequency_select_pin == FSEL_OPEN) ? HALF_HIGH :
		HALF_MID;

	// Half-period count is registered so the divider sees a clean value
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			half_cnt_ff <= HALF_MID;
		else if (ce)
			half_cnt_ff <= nxt_half_cnt;
	end

	// Mode selection: select pin low forces PWM, soft-start forces it per channel
	assign pulse_skip_operation = pins_ff.forced_pwm_select_n;
	assign forced_pwm_mode = ~pins_ff.forced_pwm_select_n;
	assign force_ccm = {2{forced_pwm_mode}} | pins_ff.soft_start;

	// Shared high-frequency clock and interleaved switching clocks
	dbcm_clkgen u_clkgen
	(
		.clk_sys      (clk_sys),
		.resetn       (resetn),
		.ce           (ce),
		.half_cnt     (half_cnt_ff),
		.hf_clk       (hf_clk),
		.hf_edge      (hf_edge),
		.period_start (period_start),
		.sw_clk       (sw_clk)
	);

	// Channel 0 runs on phase 0 of the switching period
	dbcm_channel u_ch0
	(
		.clk_sys      (clk_sys),
		.resetn       (resetn),
		.ce           (ce),
		.enable       (enable_ff && ctrl_ff[0]),
		.hf_edge      (hf_edge),
		.period_start (period_start[0]),
		.ccm_duty     (duty0_ff),
		.force_ccm    (force_ccm[0]),
		.fb_below     (pins_ff.fb_below_droop[0]),
		.il_neg       (pins_ff.il_negative[0]),
		.gate         (gate_ch0),
		.in_skip      (in_skip[0])
	);

	// Channel 1 runs half a period later, so the two are 180 degrees apart
	dbcm_channel u_ch1
	(
		.clk_sys      (clk_sys),
		.resetn       (resetn),
		.ce           (ce),
		.enable       (enable_ff && ctrl_ff[1]),
		.hf_edge      (hf_edge),
		.period_start (period_start[1]),
		.ccm_duty     (duty1_ff),
		.force_ccm    (force_ccm[1]),
		.fb_below     (pins_ff.fb_below_droop[1]),
		.il_neg       (pins_ff.il_negative[1]),
		.gate         (gate_ch1),
		.in_skip      (in_skip[1])
	);

	// Avalon request decode; every access waits exactly one cycle
	assign req = (avs_read || avs_write) && !ack_ff;
	assign take = (avs_read || avs_write) && ack_ff;
	assign avs_waitrequest = req;
	assign hit_duty0 = avs_address == REG_DUTY0;
	assign hit_duty1 = avs_address == REG_DUTY1;
	assign hit_ctrl = avs_address == REG_CTRL;
	assign hit_status = avs_address == REG_STATUS;

	// Status word shows the block's own state
	always_comb
	begin
		status_word = '0;
		status_word[ST_SKIP0] = in_skip[0];
		status_word[ST_SKIP1] = in_skip[1];
		status_word[ST_FSEL +: 2] = pins_ff.frequency_select_pin;
		status_word[ST_PSKIP] = pulse_skip_operation;
		status_word[ST_SS0] = pins_ff.soft_start[0];
		status_word[ST_SS1] = pins_ff.soft_start[1];
	end

	// Read mux; unmapped addresses read as zero
	assign nxt_rdata =
		hit_duty0  ? {{(32-DUTY_W){1'b0}}, duty0_ff} :
		hit_duty1  ? {{(32-DUTY_W){1'b0}}, duty1_ff} :
		hit_ctrl   ? {30'h0, ctrl_ff} :
		hit_status ? status_word :
		32'h0;

	// Handshake and read data; data is loaded in the wait cycle
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_ff <= 1'b0;
			rdata_ff <= '0;
		end
		else if (ce)
		begin
			ack_ff <= req;
			if (req && avs_read)
				rdata_ff <= nxt_rdata;
		end
	end

	assign avs_readdata = rdata_ff;

	// Writable registers; only byte lane 0 carries defined bits
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			duty0_ff <= DUTY_RST;
			duty1_ff <= DUTY_RST;
			ctrl_ff <= CTRL_RST;
		end
		else if (ce && take && avs_write && avs_byteenable[0])
		begin
			if (hit_duty0)
				duty0_ff <= avs_writedata[DUTY_W-1:0];
			if (hit_duty1)
				duty1_ff <= avs_writedata[DUTY_W-1:0];
			if (hit_ctrl)
				ctrl_ff <= avs_writedata[1:0];
		end
	end
endmodule

// *** tb/dbcm_top_props.sv ***
// Purpose: Concurrent checks on the clock and mode control top ports
// Assumes: ce held high; one clock domain
// Notes:   Mode checks watch channel 0; pin inputs are seen before synchronising
`timescale 1ns/1ps
module dbcm_top_props
	import dbcm_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 resetn,
	input wire dbcm_pkg::dbcm_pins_t pin_in,
	input wire logic                 avs_read,
	input wire logic                 avs_write,
	input wire logic                 avs_waitrequest,
	input wire dbcm_pkg::dbcm_gate_t gate_ch0,
	input wire dbcm_pkg::dbcm_gate_t gate_ch1,
	input wire logic                 hf_clk,
	input wire logic [1:0]           sw_clk
);
	logic        hf_q_ff;
	logic        sw0_q_ff;
	logic        sv_ff;
	logic [1:0]  fs_ff;
	logic [3:0]  hv_ff;
	logic [10:0] hcnt_ff;
	logic [10:0] scnt_ff;
	logic [10:0] lo_ff;
	logic [12:0] neg_ff;
	logic [11:0] frc_ff;
	logic        hf_chg;
	logic        skip_en0;
	logic [10:0] half_exp;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// Expected half period per select code
	assign hf_chg   = hf_clk != hf_q_ff;
	assign skip_en0 = pin_in.forced_pwm_select_n && !pin_in.soft_start[0];
	assign half_exp = (fs_ff == 2'h0) ? 11'h09c : (fs_ff == 2'h2) ? 11'h04e : 11'h068;

	// Edge history; many hf edges must pass after a select change before timing is trusted
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			hf_q_ff  <= 1'b0;
			sw0_q_ff <= 1'b0;
			sv_ff    <= 1'b0;
			fs_ff    <= 2'h0;
			hv_ff    <= 4'h0;
		end
		else
		begin
			hf_q_ff  <= hf_clk;
			sw0_q_ff <= sw_clk[0];
			sv_ff    <= sv_ff || (sw_clk[0] && !sw0_q_ff);
			fs_ff    <= pin_in.frequency_select_pin;
			if (pin_in.frequency_select_pin != fs_ff)
				hv_ff <= 4'h0;
			else if (hf_chg && hv_ff != 4'hf)
				hv_ff <= hv_ff + 4'h1;
		end
	end

	// Run lengths, saturating so long stretches stay large
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			hcnt_ff <= 11'h0;
			scnt_ff <= 11'h0;
			lo_ff   <= 11'h0;
			neg_ff  <= 13'h0;
			frc_ff  <= 12'h0;
		end
		else
		begin
			hcnt_ff <= hf_chg ? 11'h1 : hcnt_ff + {10'h0, hcnt_ff != 11'h7ff};
			scnt_ff <= (sw_clk[0] && !sw0_q_ff) ? 11'h1 : scnt_ff + {10'h0, scnt_ff != 11'h7ff};
			lo_ff   <= gate_ch0.hs ? 11'h0 : lo_ff + {10'h0, lo_ff != 11'h7ff};
			neg_ff  <= (skip_en0 && pin_in.il_negative[0]) ?
				neg_ff + {12'h0, neg_ff != 13'h1fff} : 13'h0;
			frc_ff  <= skip_en0 ? 12'h0 : frc_ff + {11'h0, frc_ff != 12'hfff};
		end
	end

	hf_half_a: assert property (hf_chg && hv_ff == 4'hf
		|-> hcnt_ff == half_exp)
		else $error("hf clock half period wrong");
	sw_period_a: assert property ($rose(sw_clk[0]) && sv_ff && hv_ff == 4'hf
		|-> scnt_ff == {half_exp[7:0], 3'h0})
		else $error("switching clock period wrong");
	sw_phase_a: assert property ($rose(sw_clk[1]) && sv_ff && hv_ff == 4'hf
		|-> scnt_ff == {half_exp[8:0], 2'h0})
		else $error("channel clocks not half a period apart");
	hs_edge_a: assert property ($rose(gate_ch0.hs) |-> hf_chg || hcnt_ff <= 11'h3)
		else $error("high side rose away from an hf edge");
	min_off_a: assert property ($rose(gate_ch0.hs) && hv_ff == 4'hf
		|-> lo_ff >= half_exp)
		else $error("high side off time too short");
	forced_comp_a: assert property (frc_ff == 12'hfff
		|-> gate_ch0.hs != gate_ch0.ls)
		else $error("low side not complement in forced mode");
	skip_ls_a: assert property (neg_ff == 13'h1fff && lo_ff > 11'h8
		|-> !gate_ch0.ls)
		else $error("low side on with negative current");
	gate_excl_a: assert property (!(gate_ch0.hs && gate_ch0.ls) && !(gate_ch1.hs && gate_ch1.ls))
		else $error("both switches of a channel on");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait cycle");
endmodule

bind dbcm_top dbcm_top_props props_u
(
	.clk_sys(clk_sys),
	.resetn(resetn),
	.pin_in(pin_in),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.gate_ch0(gate_ch0),
	.gate_ch1(gate_ch1),
	.hf_clk(hf_clk),
	.sw_clk(sw_clk)
);

// *** tb/dbcm_stage_model.sv ***
// Purpose: Power stage and feedback comparators seen from the gate drives
// Assumes: Light load keeps inductor current negative throughout
// Notes:   Output sags once the high side has idled GAP cycles
`timescale 1ns/1ps
module dbcm_stage_model
	import dbcm_pkg::*;
#(
	parameter int GAP = 200
)
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 light,
	input  wire dbcm_pkg::dbcm_gate_t gate_ch0,
	input  wire dbcm_pkg::dbcm_gate_t gate_ch1,
	output logic [1:0]                fb_below_droop,
	output logic [1:0]                il_negative
);
	logic [7:0] idle0_ff;
	logic [7:0] idle1_ff;

	// Idle time since each high-side pulse, held at its ceiling
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			idle0_ff <= 8'h0;
			idle1_ff <= 8'h0;
		end
		else
		begin
			idle0_ff <= gate_ch0.hs ? 8'h0 : idle0_ff + {7'h0, idle0_ff != 8'hff};
			idle1_ff <= gate_ch1.hs ? 8'h0 : idle1_ff + {7'h0, idle1_ff != 8'hff};
		end
	end

	// Sag pulls feedback below the droop node whatever the load
	assign fb_below_droop = {idle1_ff >= 8'(GAP), idle0_ff >= 8'(GAP)};
	assign il_negative    = {light, light};
endmodule

// *** tb/dbcm_top_tb.sv ***
// Purpose: Self-checking bench for the clock and mode control top
// Assumes: ce tied high; pins change just after a rising edge
// Notes:   Skip mode is reached through the stage model light-load flag
`timescale 1ns/1ps
module dbcm_top_tb;
	import dbcm_pkg::*;
	logic        clk_sys;
	logic        resetn;
	logic        enable;
	logic        pfs_n;
	logic [1:0]  fsel;
	logic [1:0]  ss;
	logic        light;
	logic [1:0]  psel;
	logic [1:0]  fb;
	logic [1:0]  il;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	dbcm_gate_t  gate_ch0;
	dbcm_gate_t  gate_ch1;
	logic        hf_clk;
	logic [1:0]  sw_clk;
	logic [31:0] rd;
	dbcm_pins_t  pin_in;
	logic        probe;
	int          fail_count;
	int          n_checks;
	int          w;
	int          half_tab[4] = '{156, 104, 78, 104};

	// Pins from the bench and the stage model; probe picks what span measures
	assign pin_in = {pfs_n, fsel, ss, fb, il};
	assign probe  = (psel == 2'h0) ? hf_clk : (psel == 2'h1) ? gate_ch0.hs : fb[0];

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	dbcm_top dut_u
	(
		.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .enable(enable), .pin_in(pin_in),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.gate_ch0(gate_ch0), .gate_ch1(gate_ch1), .hf_clk(hf_clk), .sw_clk(sw_clk)
	);

	dbcm_stage_model #(.GAP(200)) stage_u
	(
		.clk_sys(clk_sys), .resetn(resetn), .light(light), .gate_ch0(gate_ch0),
		.gate_ch1(gate_ch1), .fb_below_droop(fb), .il_negative(il)
	);

	task automatic test_done;
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One transfer; waitrequest and read data are taken at the same rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		logic wq;
		int   n;
		n = 0;
		@(posedge clk_sys);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		do
		begin
			@(posedge clk_sys);
			wq = avs_waitrequest;
			rd = avs_readdata;
			n++;
		end
		while (wq !== 1'b0 && n < 20);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (wq !== 1'b0)
		begin
			chk("bus wait", 32'h1, 32'h0);
			test_done;
		end
	endtask

	task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'h0);
		chk(nm, rd, exp);
	endtask

	task automatic step(inout int n);
		@(negedge clk_sys);
		n++;
	endtask

	// Length of the next whole high stretch of the probe, in cycles
	task automatic span(input logic [1:0] s, output int hi);
		int n;
		psel = s;
		n    = 0;
		hi   = 0;
		while (probe !== 1'b0 && n < 9000)
			step(n);
		while (probe !== 1'b1 && n < 9000)
			step(n);
		while (probe === 1'b1 && n < 9000)
		begin
			step(n);
			hi++;
		end
		if (n >= 9000)
		begin
			chk("probe wait", 32'h1, 32'h0);
			test_done;
		end
		@(posedge clk_sys);
	endtask

	// Main sequence
	initial
	begin
		fail_count = 0;
		n_checks = 0;
		resetn = 1'b0;
		enable = 1'b1;
		pfs_n = 1'b0;
		fsel = 2'h1;
		ss = 2'h0;
		light = 1'b0;
		psel = 2'h0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		rchk("duty0", REG_DUTY0, 32'h3);
		rchk("duty1", REG_DUTY1, 32'h3);
		rchk("ctrl", REG_CTRL, 32'h3);
		rchk("hole", 4'h2, 32'h0);
		bus(1'b1, REG_STATUS, 32'hff, 4'hf);
		rchk("status forced", REG_STATUS, 32'h04);
		for (int i = 0; i < 4; i++)
		begin
			fsel <= 2'(i);
			repeat (3) span(2'h0, w);
			chk("hf half", w, half_tab[i]);
		end
		fsel <= 2'h1;
		bus(1'b1, REG_DUTY0, 32'h5, 4'h1);
		bus(1'b1, REG_DUTY0, 32'h7, 4'h0);
		rchk("duty0 kept", REG_DUTY0, 32'h5);
		repeat (2) span(2'h1, w);
		chk("ccm on time", w, 5 * 104);
		bus(1'b1, REG_DUTY0, 32'h2, 4'h1);
		pfs_n <= 1'b1;
		light <= 1'b1;
		bus(1'b1, REG_CTRL, 32'h1, 4'h1);
		repeat (2000) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("ch1 off", gate_ch1, 2'h0);
		bus(1'b1, REG_CTRL, 32'h3, 4'h1);
		repeat (10000) @(posedge clk_sys);
		rchk("status skip", REG_STATUS, 32'h17);
		span(2'h1, w);
		chk("skip on time", w, 3 * 104);
		span(2'h2, w);
		chk("pulse latency", (w > 2 && w <= 110), 1);
		ss <= 2'h1;
		repeat (5000) @(posedge clk_sys);
		rchk("status soft start", REG_STATUS, 32'h36);
		ss <= 2'h0;
		light <= 1'b0;
		repeat (5000) @(posedge clk_sys);
		rchk("status heavy", REG_STATUS, 32'h14);
		pfs_n <= 1'b0;
		repeat (5000) @(posedge clk_sys);
		rchk("status back", REG_STATUS, 32'h04);
		test_done;
	end
endmodule
